// file: design/timer8_waveform_generator.sv
// timer8_waveform_generator: 8-bit timer, two compare channels, AXI4-Lite
//
// Contract
// - mode 0 counts up only, wrapping from 0xFF to 0x00.
// - normal mode sets overflow flag when count becomes zero; never clears it.
// - mode 2 clears counter the cycle after matching compare A.
// - mode 2 compare A writes are immediate; lower value wraps through 0xFF.
// - mode 2 with action 1 toggles output A on every compare A match.
// - mode 2 sets overflow flag on rollover from max to 0x00.
// - timer enable divides clock by 1, 8, 32, 64, 128, 256, 1024.
// - fast PWM counts bottom to top then clears; top 0xFF mode 3, A mode 7.
// - fast PWM sets overflow flag whenever counter reaches top.
// - PWM modes: action 2 non-inverted, action 3 inverted output.
// - fast PWM non-inverted clears on match, sets at top-to-bottom.
// - fast PWM compare zero spikes; compare max holds output constant.
// - fast PWM action 1 toggles on match; compare stays double buffered.
// - modes 1 and 5 count up and down; top 0xFF or compare A.
// - phase-correct reverses at top; count equals top one timer cycle.
// - phase-correct non-inverted clears on up match, sets on down match.
// - phase-correct sets overflow flag on reaching bottom.
// - phase-correct compare zero holds low, max holds high when top is 0xFF (non-inverted).
// - phase-correct makes up-match transition at top if no match occurred.
// - equality with a compare register sets its flag next timer cycle.
// - compare flags clear by writing one; writing zero leaves them.
// - PWM compare writes go to a buffer; otherwise directly active.
// - count write beats clear or count; clock select zero stops counter.
// - output action zero leaves channel output unchanged on match.
// - count write suppresses compare matches in next timer cycle.
// - non-PWM force strobe updates output only, no flag, no clear.
`timescale 1ns/1ps

module timer8_waveform_generator
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // waveform outputs
  output logic wave_out_a,
  output logic wave_out_b,
  output timer8_pkg::timer_flags_t flags
);

  // ===========================================================
  // state
  timer_ctrl_t ctrl;
  logic [7:0] count_value;
  logic [7:0] compare_a_value;
  logic [7:0] compare_b_value;
  logic [7:0] compare_a_buffer;
  logic [7:0] compare_b_buffer;
  logic count_down;
  logic block_match;
  logic [PRESCALE_W-1:0] prescale;

  // ===========================================================
  // bus slave: address and data may arrive in either order
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;

  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // each ready is registered: high only while its own channel holds nothing and no response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      awready <= !aw_held && !(awvalid && awready) && !bvalid;
      wready <= !w_held && !(wvalid && wready) && !bvalid;
    end
  end

  logic addr_ok;
  always_comb begin
    if (aw_addr_q == ADDR_CONTROL) addr_ok = 1'b1;
    else if (aw_addr_q == ADDR_COUNT) addr_ok = 1'b1;
    else if (aw_addr_q == ADDR_COMPARE_A) addr_ok = 1'b1;
    else if (aw_addr_q == ADDR_COMPARE_B) addr_ok = 1'b1;
    else if (aw_addr_q == ADDR_FLAGS) addr_ok = 1'b1;
    else if (aw_addr_q == ADDR_STATUS) addr_ok = 1'b1;
    else addr_ok = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= addr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // register write strobes, byte lane 0 carries all fields except the output actions and force, which lane 1 carries
  logic lane0;
  logic lane1;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_flags;
  assign lane0 = w_strb_q[0];
  assign lane1 = w_strb_q[1];
  assign wr_ctrl = wr_fire && (aw_addr_q == ADDR_CONTROL);
  assign wr_count = wr_fire && (aw_addr_q == ADDR_COUNT) && lane0;
  assign wr_cmp_a = wr_fire && (aw_addr_q == ADDR_COMPARE_A) && lane0;
  assign wr_cmp_b = wr_fire && (aw_addr_q == ADDR_COMPARE_B) && lane0;
  assign wr_flags = wr_fire && (aw_addr_q == ADDR_FLAGS) && lane0;

  // ===========================================================
  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      if (lane0) begin
        ctrl.wave_mode_sel <= w_data_q[MODE_LSB +: 3];
        ctrl.clock_source_sel <= w_data_q[CLKSEL_LSB +: 3];
      end
      if (lane1) begin
        ctrl.chan_a_output_action <= w_data_q[ACT_A_LSB +: 2];
        ctrl.chan_b_output_action <= w_data_q[ACT_B_LSB +: 2];
      end
    end
  end

  // ===========================================================
  // mode decode
  logic fast_mode;
  logic pc_mode;
  logic pwm_mode;
  logic [7:0] top_value;
  assign fast_mode = (ctrl.wave_mode_sel == MODE_FAST_MAX) ||
                     (ctrl.wave_mode_sel == MODE_FAST_CMPA);
  assign pc_mode = (ctrl.wave_mode_sel == MODE_PC_MAX) ||
                   (ctrl.wave_mode_sel == MODE_PC_CMPA);
  assign pwm_mode = fast_mode || pc_mode;
  assign top_value = (ctrl.wave_mode_sel == MODE_FAST_CMPA ||
                      ctrl.wave_mode_sel == MODE_PC_CMPA ||
                      ctrl.wave_mode_sel == MODE_CLEAR) ?
                     compare_a_value : COUNT_MAX;

  // ===========================================================
  // prescaler: tick is a one-cycle timer clock enable
  logic tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) prescale <= '0;
    else prescale <= prescale + 1'b1;
  end

  // a tick fires when all low bits of the divider are ones
  always_comb begin
    case (ctrl.clock_source_sel)
      CLK_DIV1: tick = 1'b1;
      CLK_DIV8: tick = &prescale[2:0];
      CLK_DIV32: tick = &prescale[4:0];
      CLK_DIV64: tick = &prescale[5:0];
      CLK_DIV128: tick = &prescale[6:0];
      CLK_DIV256: tick = &prescale[7:0];
      CLK_DIV1024: tick = &prescale[9:0];
      default: tick = 1'b0;
    endcase
  end

  // ===========================================================
  // counter
  logic at_top;
  logic at_bottom;
  logic fast_wrap;
  assign at_top = (count_value == top_value);
  assign at_bottom = (count_value == COUNT_BOTTOM);
  assign fast_wrap = fast_mode && at_top;

  logic [7:0] next_count;
  logic next_down;
  always_comb begin
    next_count = count_value;
    next_down = count_down;
    if (pc_mode) begin
      if (at_top && !count_down) next_down = 1'b1;
      else if (at_bottom && count_down) next_down = 1'b0;
      if (next_down) next_count = count_value - 1'b1;
      else next_count = count_value + 1'b1;
    end else if (fast_wrap) begin
      next_count = COUNT_BOTTOM;
    end else if (ctrl.wave_mode_sel == MODE_CLEAR && !block_match &&
                 count_value == compare_a_value) begin
      next_count = COUNT_BOTTOM;
    end else begin
      next_count = count_value + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= COUNT_BOTTOM;
      count_down <= 1'b0;
    end else if (wr_count) begin
      count_value <= w_data_q[7:0];
    end else if (tick) begin
      count_value <= next_count;
      count_down <= pwm_mode ? next_down : 1'b0;
    end
  end

  // matches seen at a tick act on the following tick
  logic raw_a;
  logic raw_b;
  assign raw_a = (count_value == compare_a_value) && !block_match;
  assign raw_b = (count_value == compare_b_value) && !block_match;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_match <= 1'b0;
    end else if (wr_count) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // ===========================================================
  // compare registers and their buffers
  logic load_pt;
  assign load_pt = tick && ((fast_mode && fast_wrap) ||
                            (pc_mode && at_top && !count_down));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_buffer <= COUNT_BOTTOM;
      compare_b_buffer <= COUNT_BOTTOM;
    end else begin
      if (wr_cmp_a) compare_a_buffer <= w_data_q[7:0];
      if (wr_cmp_b) compare_b_buffer <= w_data_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_value <= COUNT_BOTTOM;
      compare_b_value <= COUNT_BOTTOM;
    end else if (!pwm_mode) begin
      if (wr_cmp_a) compare_a_value <= w_data_q[7:0];
      if (wr_cmp_b) compare_b_value <= w_data_q[7:0];
    end else if (load_pt) begin
      compare_a_value <= compare_a_buffer;
      compare_b_value <= compare_b_buffer;
    end
  end

  // ===========================================================
  // flags: hardware set wins over a software clear
  logic ovf_evt;
  assign ovf_evt = tick && (pc_mode ? (next_count == COUNT_BOTTOM &&
                                       count_down)
                                    : (fast_mode ? fast_wrap
                                                 : count_value == COUNT_MAX));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else begin
      if (ovf_evt) flags.overflow_flag <= 1'b1;
      else if (wr_flags && w_data_q[OVF_BIT]) flags.overflow_flag <= 1'b0;
      if (tick && raw_a) flags.compare_a_flag <= 1'b1;
      else if (wr_flags && w_data_q[CMPA_BIT])
        flags.compare_a_flag <= 1'b0;
      if (tick && raw_b) flags.compare_b_flag <= 1'b1;
      else if (wr_flags && w_data_q[CMPB_BIT])
        flags.compare_b_flag <= 1'b0;
    end
  end

  // ===========================================================
  // waveform generator, one channel per generate pass
  logic [1:0] act [2];
  logic [1:0] hit;
  logic [1:0] forced;
  logic [7:0] cmp [2];
  logic [1:0] wave;
  assign act[0] = ctrl.chan_a_output_action;
  assign act[1] = ctrl.chan_b_output_action;
  assign cmp[0] = compare_a_value;
  assign cmp[1] = compare_b_value;
  assign hit = {raw_b, raw_a};
  assign forced = {wr_ctrl && lane1 && w_data_q[FORCE_B_BIT],
                   wr_ctrl && lane1 && w_data_q[FORCE_A_BIT]};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic up_done;
      logic inv;
      assign inv = (act[ch] == ACT_SET);

      // tracks whether the up-slope match happened this period
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          up_done <= 1'b0;
        end else if (tick && pc_mode) begin
          if (at_bottom) up_done <= 1'b0;
          else if (hit[ch] && !count_down) up_done <= 1'b1;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          wave[ch] <= 1'b0;
        end else if (!pwm_mode) begin
          if ((tick && hit[ch]) || forced[ch]) begin
            case (act[ch])
              ACT_TOGGLE: wave[ch] <= !wave[ch];
              ACT_CLEAR: wave[ch] <= 1'b0;
              ACT_SET: wave[ch] <= 1'b1;
              default: wave[ch] <= wave[ch];
            endcase
          end
        end else if (tick && act[ch] != ACT_NONE) begin
          if (fast_mode) begin
            if (act[ch] == ACT_TOGGLE) begin
              if (hit[ch]) wave[ch] <= !wave[ch];
            end else if (hit[ch] && cmp[ch] != top_value) begin
              wave[ch] <= inv;
            end else if (fast_wrap) begin
              wave[ch] <= !inv;
            end
          end else if (act[ch] != ACT_TOGGLE) begin
            if (hit[ch] && cmp[ch] == COUNT_MAX && at_top) begin
              wave[ch] <= !inv;
            end else if (hit[ch] && (!count_down || at_bottom)) begin
              // a match at bottom acts as an up match, so zero holds low when non-inverted
              wave[ch] <= inv;
            end else if (hit[ch] && count_down) begin
              wave[ch] <= !inv;
            end else if (at_top && !count_down && !up_done) begin
              wave[ch] <= inv;
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      wave_out_a <= wave[0];
      wave_out_b <= wave[1];
    end
  end

  // ===========================================================
  // read channel: one read at a time, answer one cycle after arready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
    end else begin
      arready <= !arready && !rvalid && arvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      if (araddr == ADDR_CONTROL) begin
        rdata[MODE_LSB +: 3] <= ctrl.wave_mode_sel;
        rdata[CLKSEL_LSB +: 3] <= ctrl.clock_source_sel;
        rdata[ACT_A_LSB +: 2] <= ctrl.chan_a_output_action;
        rdata[ACT_B_LSB +: 2] <= ctrl.chan_b_output_action;
      end else if (araddr == ADDR_COUNT) begin
        rdata[7:0] <= count_value;
      end else if (araddr == ADDR_COMPARE_A) begin
        rdata[7:0] <= pwm_mode ? compare_a_buffer : compare_a_value;
      end else if (araddr == ADDR_COMPARE_B) begin
        rdata[7:0] <= pwm_mode ? compare_b_buffer : compare_b_value;
      end else if (araddr == ADDR_FLAGS) begin
        rdata[2:0] <= flags;
      end else if (araddr == ADDR_STATUS) begin
        rdata[0] <= count_down;
        rdata[2:1] <= {wave[1], wave[0]};
      end else begin
        rresp <= RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : timer8_waveform_generator

// file: design/timer8_pkg.sv
// timer8_pkg: register map, field layout and mode codes of the 8-bit timer
package timer8_pkg;

  // ===========================================================
  // register byte addresses
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_COMPARE_A = 12'h008;
  localparam logic [11:0] ADDR_COMPARE_B = 12'h00C;
  localparam logic [11:0] ADDR_FLAGS = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;

  // ===========================================================
  // control register field positions
  localparam int MODE_LSB = 0;
  localparam int CLKSEL_LSB = 4;
  localparam int ACT_A_LSB = 8;
  localparam int ACT_B_LSB = 10;
  localparam int FORCE_A_BIT = 12;
  localparam int FORCE_B_BIT = 13;

  // flag register bit positions
  localparam int OVF_BIT = 0;
  localparam int CMPA_BIT = 1;
  localparam int CMPB_BIT = 2;

  // ===========================================================
  // counter constants
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // ===========================================================
  // waveform mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CLEAR = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_CMPA = 3'h5;
  localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

  // output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // clock source codes, 0 stops the counter
  localparam logic [2:0] CLK_STOP = 3'h0;
  localparam logic [2:0] CLK_DIV1 = 3'h1;
  localparam logic [2:0] CLK_DIV8 = 3'h2;
  localparam logic [2:0] CLK_DIV32 = 3'h3;
  localparam logic [2:0] CLK_DIV64 = 3'h4;
  localparam logic [2:0] CLK_DIV128 = 3'h5;
  localparam logic [2:0] CLK_DIV256 = 3'h6;
  localparam logic [2:0] CLK_DIV1024 = 3'h7;

  localparam int PRESCALE_W = 10;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===========================================================
  // carriers
  typedef struct packed {
    logic [2:0] wave_mode_sel;
    logic [2:0] clock_source_sel;
    logic [1:0] chan_a_output_action;
    logic [1:0] chan_b_output_action;
  } timer_ctrl_t;

  typedef struct packed {
    logic compare_b_flag;
    logic compare_a_flag;
    logic overflow_flag;
  } timer_flags_t;

endpackage : timer8_pkg

// file: tb/timer8_waveform_generator_asserts.sv
// timer8_waveform_generator_asserts: port-level checks of the timer block
`timescale 1ns/1ps

module timer8_waveform_generator_asserts
  import timer8_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // timer outputs
  input wire timer8_pkg::timer_flags_t flags
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // helper: low data bits carrying a one in the write under way
  logic [2:0] clr_pend;
  always_ff @(posedge aclk) begin
    if (!aresetn) clr_pend <= 3'h0;
    else if (wvalid && wready) clr_pend <= wdata[2:0];
    else if (bvalid && bready) clr_pend <= 3'h0;
  end

  // ==========================================================
  // sequences
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_ar_taken;
    arvalid && arready;
  endsequence

  // ==========================================================
  // assertions
  AST_OVF_ONLY_SET: assert property (
    $fell(flags.overflow_flag) && $past(aresetn)
    |-> clr_pend[0] || $past(clr_pend[0]))
    else $error("overflow flag fell without a clearing write");
  AST_CMPA_CLEAR_BY_ONE: assert property (
    $fell(flags.compare_a_flag) && $past(aresetn)
    |-> clr_pend[1] || $past(clr_pend[1]))
    else $error("compare a flag fell without a clearing write");
  AST_CMPB_CLEAR_BY_ONE: assert property (
    $fell(flags.compare_b_flag) && $past(aresetn)
    |-> clr_pend[2] || $past(clr_pend[2]))
    else $error("compare b flag fell without a clearing write");
  AST_B_ANSWER: assert property (s_both_taken |-> ##[1:3] bvalid)
    else $error("write response late");
  AST_B_HOLDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  AST_R_ANSWER: assert property (s_ar_taken |=> rvalid)
    else $error("read data not one cycle after address");
  AST_R_HOLDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before rready");
  AST_AR_PULSE: assert property (arready |=> !arready)
    else $error("arready longer than one cycle");
  AST_NO_ACCEPT_IN_B: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  AST_SLVERR_ZERO: assert property (
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("refused read carries data");
endmodule : timer8_waveform_generator_asserts

bind timer8_waveform_generator timer8_waveform_generator_asserts i_asserts (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .flags(flags));

// file: tb/tb_timer8_waveform_generator.sv
// tb_timer8_waveform_generator: directed bus-driven bench for the timer
`timescale 1ns/1ps

module tb_timer8_waveform_generator;
  import timer8_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, wave_out_a, wave_out_b;
  logic [1:0] bresp, rresp, lvl;
  logic [31:0] rdata;
  logic hi;
  timer_flags_t flags;
  int num_errors = 0, n_compared = 0, cyc = 0, t0;
  int pre[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  timer8_waveform_generator i_timer8_waveform_generator (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .flags(flags));

  // ==========================================================
  // reporting
  task automatic final_report();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // ==========================================================
  // bus access
  task automatic wr(logic [11:0] a, logic [31:0] d,
                    logic [1:0] er = RESP_OKAY);
    // one idle edge so bready is never lowered and raised in one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", er, bresp);
  endtask : wr

  task automatic rdchk(logic [11:0] a, logic [31:0] e,
                       logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    check("rdata", e, rdata);
    check("rresp", er, rresp);
  endtask : rdchk

  function automatic logic [31:0] cw(logic [2:0] m, logic [2:0] c,
                                     logic [1:0] a, logic [1:0] b);
    return 32'(m) | (32'(c) << CLKSEL_LSB) | (32'(a) << ACT_A_LSB)
      | (32'(b) << ACT_B_LSB);
  endfunction : cw

  // ==========================================================
  // event timing: 0 ovf, 1 cmp a, 2 cmp b, 3 wave a
  function automatic logic sig(int s);
    logic [3:0] v;
    v = {wave_out_a, flags};
    return v[s];
  endfunction : sig

  task automatic wait_lvl(int s, logic l);
    int n;
    n = 0;
    while (sig(s) !== l) begin
      @(posedge aclk);
      n++;
      if (n > 5000) begin
        num_errors++;
        $display("BAD wait on %0d expected %0b seen %0b", s, l, sig(s));
        return;
      end
    end
  endtask : wait_lvl

  task automatic edge_to(int s, logic l);
    wait_lvl(s, !l);
    wait_lvl(s, l);
  endtask : edge_to

  task automatic gap(int s1, logic l1, int s2, logic l2, int exp);
    edge_to(s1, l1);
    t0 = cyc;
    edge_to(s2, l2);
    check("interval", exp, cyc - t0);
  endtask : gap

  // ==========================================================
  // cycle ceiling well above the longest expected run
  always @(posedge aclk) begin
    if (cyc == 90000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("flags", 0, flags);
    check("wave_a", 0, wave_out_a);
    rdchk(ADDR_CONTROL, 0);
    rdchk(ADDR_COUNT, 0);
    rdchk(12'h020, 0, RESP_SLVERR);
    wr(12'h020, 32'hFF, RESP_SLVERR);
    // compare a at 3 lands four timer ticks after the wrap
    for (int i = 1; i < 8; i++) begin
      wr(ADDR_CONTROL, 0);
      wr(ADDR_COUNT, 32'hFD);
      wr(ADDR_COMPARE_A, 32'h3);
      wr(ADDR_FLAGS, 32'h7);
      wr(ADDR_CONTROL, cw(MODE_NORMAL, 3'(i), ACT_NONE, ACT_NONE));
      gap(0, 1, 1, 1, 4 * pre[i]);
    end
    wr(ADDR_CONTROL, 0);
    check("flags", 7, flags);
    wr(ADDR_FLAGS, 0);
    check("flags", 7, flags);
    wr(ADDR_FLAGS, 2);
    check("flags", 5, flags);
    wr(ADDR_COUNT, 32'h5A);
    rdchk(ADDR_COUNT, 32'h5A);
    // fast pwm, a non-inverted, b inverted
    wr(ADDR_COMPARE_A, 32'h40);
    wr(ADDR_COMPARE_B, 32'h40);
    wr(ADDR_CONTROL, cw(MODE_FAST_MAX, CLK_DIV1, ACT_CLEAR, ACT_SET));
    gap(3, 1, 3, 0, 32'h41);
    check("wave_b", 1, wave_out_b);
    edge_to(3, 1);
    t0 = cyc;
    wr(ADDR_COMPARE_A, 32'h20);
    edge_to(3, 0);
    check("interval", 32'h41, cyc - t0);
    gap(3, 1, 3, 0, 32'h21);
    wr(ADDR_COMPARE_A, 0);
    gap(3, 1, 3, 0, 1);
    // phase-correct pwm, top at max
    wr(ADDR_CONTROL, cw(MODE_PC_MAX, CLK_STOP, ACT_CLEAR, ACT_SET));
    wr(ADDR_COUNT, 32'hFD);
    wr(ADDR_COMPARE_A, 32'h40);
    wr(ADDR_FLAGS, 32'h7);
    wr(ADDR_CONTROL, cw(MODE_PC_MAX, CLK_DIV1, ACT_CLEAR, ACT_SET));
    gap(1, 1, 0, 1, 63);
    gap(3, 1, 3, 0, 32'h80);
    gap(3, 0, 3, 1, 382);
    wr(ADDR_COMPARE_A, 0);
    wr(ADDR_COMPARE_B, 0);
    repeat (600) @(posedge aclk);
    hi = 1'b0;
    repeat (520) begin
      @(posedge aclk);
      hi = hi | wave_out_a | !wave_out_b;
    end
    check("pc_levels", 0, hi);
    // clear on match with toggle; start above compare to force a wrap
    wr(ADDR_CONTROL, cw(MODE_CLEAR, CLK_STOP, ACT_TOGGLE, ACT_NONE));
    wr(ADDR_COUNT, 32'hA);
    wr(ADDR_COMPARE_A, 32'h4);
    wr(ADDR_FLAGS, 32'h7);
    wr(ADDR_CONTROL, cw(MODE_CLEAR, CLK_DIV1, ACT_TOGGLE, ACT_NONE));
    gap(0, 1, 1, 1, 5);
    gap(3, 1, 3, 0, 5);
    // count write equal to compare a while stopped hides the first match
    wr(ADDR_CONTROL, cw(MODE_NORMAL, CLK_STOP, ACT_TOGGLE, ACT_NONE));
    wr(ADDR_FLAGS, 32'h7);
    wr(ADDR_COUNT, 32'h4);
    wr(ADDR_CONTROL, cw(MODE_NORMAL, CLK_DIV1, ACT_TOGGLE, ACT_NONE));
    repeat (20) @(posedge aclk);
    check("cmp_a_flag", 0, flags.compare_a_flag);
    wait_lvl(1, 1);
    // force strobes: a toggles, b has no action
    wr(ADDR_CONTROL, cw(MODE_NORMAL, CLK_STOP, ACT_TOGGLE, ACT_NONE));
    wr(ADDR_FLAGS, 32'h7);
    lvl = {wave_out_b, wave_out_a};
    wr(ADDR_CONTROL, cw(MODE_NORMAL, CLK_STOP, ACT_TOGGLE, ACT_NONE)
      | (32'h1 << FORCE_A_BIT) | (32'h1 << FORCE_B_BIT));
    @(posedge aclk);
    check("waves", {lvl[1], !lvl[0]}, {wave_out_b, wave_out_a});
    check("flags", 0, flags);
    // fast pwm with compare a as top: toggle gives top plus one per level
    wr(ADDR_CONTROL, cw(MODE_FAST_CMPA, CLK_DIV1, ACT_TOGGLE, ACT_NONE));
    gap(3, 1, 3, 0, 5);
    final_report();
  end
endmodule : tb_timer8_waveform_generator
